// ### hw/mvc_move_cmd.sv
// Numeric move command write: parses ASCII write-multiple queries into the
// move command registers, echoes, and issues move starts to the motion engine.
// Assumes rx/tx characters come from a UART on sys_clk; limits are static.
// Notes on behaviour
// (RL1) Query fields in order, at most 256 characters
// (RL2) Address is axis plus one; zero is broadcast
// (RL3) Byte count equals twice the register count
// (RL4) Reply echoes header fields, 17 characters total
// (RL5) Target position absolute, 0.01 mm, bounded range
// (RL6) Negative target sent as two's complement
// (RL7) Beyond soft limit: stop 0.2 mm short
// (RL8) Rotary index axis: clamp exactly to limit
// (RL9) Target lower word write starts a move
// (RL10) Band is tolerance or push band per flag
// (RL11) Band write alone starts nothing
// (RL12) Band no smaller than lead per pulse; code only checks 1 to 999999
// (RL13) Speed in 0.01 mm/s, 1 to 999999
// (RL14) Speed over maximum alarms at move start
// (RL15) Speed lower word write starts or updates move
// (RL16) Acceleration in 0.01 G, 1 to 300
// (RL17) Acceleration over maximum alarms at move start
// (RL18) Acceleration write starts or updates move
// (RL19) Push current within its model range; code applies it unchecked
// (RL20) Push current write starts or updates push
// (RL21) Current percent scaled by 255
// (RL22) Control flags return to default after moves
// (RL23) Flag bit 1 selects push motion
// (RL24) Bad LRC discarded; broadcast gets no reply
// (RL25) Whole query applied before start evaluation
module mvc_move_cmd (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Received characters
   input wire logic [7:0] rx_char,
   input wire logic rx_valid,
   // Response characters
   output logic [7:0] tx_char,
   output logic tx_valid,
   input wire logic tx_ready,
   // Axis settings
   input wire logic [3:0] axis_num,
   input wire logic [31:0] soft_limit_lo,
   input wire logic [31:0] soft_limit_hi,
   input wire logic rotary_index,
   input wire logic [31:0] max_speed,
   input wire logic [15:0] max_accel,
   // Motion engine
   input wire logic move_done,
   input wire logic [31:0] current_pos,
   output logic move_start,
   output logic [31:0] target_position,
   output logic [31:0] positioning_band,
   output logic [31:0] move_speed,
   output logic [15:0] move_acceleration,
   output logic [15:0] push_current_limit,
   output logic [15:0] motion_control_flags,
   output logic push_mode,
   output logic in_position,
   // Alarms
   output logic speed_alarm,
   output logic accel_alarm
);

   mvc_pkg::mvc_state_e state_r;
   logic [3:0] nib;
   logic is_hex;
   logic half_r;
   logic [3:0] hi_r;
   logic byte_v;
   logic [7:0] rx_byte;
   logic [7:0] byte_idx_r;
   logic [8:0] char_cnt_r;
   logic bad_r;
   logic [7:0] lrc_r;
   logic [7:0] addr_r;
   logic [7:0] func_r;
   logic [7:0] bc_r;
   logic [15:0] sa_r;
   logic [15:0] cnt_r;
   logic [7:0] dhi_r;
   logic [15:0] stage_r [mvc_pkg::NUM_WORDS];
   logic [8:0] mask_r;
   logic [15:0] word_r [mvc_pkg::NUM_WORDS];
   logic [15:0] nv [mvc_pkg::NUM_WORDS];
   logic [7:0] dk;
   logic in_data;
   logic [15:0] widx;
   logic is_colon;
   logic frame_end;
   logic addr_match;
   logic vals_ok;
   logic frame_ok;
   logic commit;
   logic eval_r;
   logic trig_r;
   logic [31:0] tgt;
   logic [31:0] tgt_clamped;
   logic [31:0] cmd_target_r;
   logic move_start_r;
   logic spd_alarm_r;
   logic acc_alarm_r;
   logic in_pos_r;
   logic [31:0] pos_diff;
   logic [31:0] pos_abs;

   mvc_hex_dec u_hex (
      .ch(rx_char),
      .nib(nib),
      .is_hex(is_hex)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Character framing
   assign is_colon = rx_valid && rx_char == mvc_pkg::CH_COLON;
   assign byte_v = rx_valid && state_r == mvc_pkg::MVC_BODY && is_hex && half_r;
   assign rx_byte = {hi_r, nib};
   assign frame_end = rx_valid && state_r == mvc_pkg::MVC_TRAIL
                      && rx_char == mvc_pkg::CH_LF;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= mvc_pkg::MVC_IDLE;
         half_r <= 1'b0;
         hi_r <= 4'h0;
         byte_idx_r <= 8'h00;
         char_cnt_r <= 9'h000;
      end else if (is_colon) begin
         // A header always restarts, so a torn frame cannot swallow the next
         state_r <= mvc_pkg::MVC_BODY;
         half_r <= 1'b0;
         byte_idx_r <= 8'h00;
         char_cnt_r <= 9'h001;
      end else if (rx_valid) begin
         if (char_cnt_r != 9'h1FF) begin
            char_cnt_r <= 9'(char_cnt_r + 9'h001);
         end
         case (state_r)
            mvc_pkg::MVC_BODY: begin
               if (is_hex) begin
                  half_r <= !half_r;
                  hi_r <= nib;
                  if (half_r) begin
                     byte_idx_r <= 8'(byte_idx_r + 8'h01);
                  end
               end else if (rx_char == mvc_pkg::CH_CR) begin
                  state_r <= mvc_pkg::MVC_TRAIL;
               end else begin
                  state_r <= mvc_pkg::MVC_IDLE;
               end
            end
            mvc_pkg::MVC_TRAIL: state_r <= mvc_pkg::MVC_IDLE;
            default: state_r <= mvc_pkg::MVC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Header fields, LRC sum and frame faults
   assign dk = 8'(byte_idx_r - mvc_pkg::HDR_BYTES);
   assign in_data = byte_idx_r >= mvc_pkg::HDR_BYTES
                    && {9'h000, dk} < {cnt_r, 1'b0};
   assign widx = 16'(sa_r - mvc_pkg::REG_BASE + {9'h000, dk[7:1]});

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_r <= 8'h00;
         func_r <= 8'h00;
         sa_r <= 16'h0000;
         cnt_r <= 16'h0000;
         bc_r <= 8'h00;
         dhi_r <= 8'h00;
         lrc_r <= 8'h00;
         bad_r <= 1'b0;
      end else if (is_colon) begin
         lrc_r <= 8'h00;
         bad_r <= 1'b0;
      end else if (byte_v) begin
         lrc_r <= 8'(lrc_r + rx_byte);
         case (byte_idx_r)
            8'h00: addr_r <= rx_byte;
            8'h01: func_r <= rx_byte;
            8'h02: sa_r[15:8] <= rx_byte;
            8'h03: sa_r[7:0] <= rx_byte;
            8'h04: cnt_r[15:8] <= rx_byte;
            8'h05: cnt_r[7:0] <= rx_byte;
            8'h06: bc_r <= rx_byte;
            default: dhi_r <= rx_byte;
         endcase
         if (in_data && sa_r < mvc_pkg::REG_BASE) begin
            bad_r <= 1'b1;
         end
         if (in_data && widx >= mvc_pkg::NUM_WORDS_16) begin
            bad_r <= 1'b1;
         end
      end else if (rx_valid && char_cnt_r >= mvc_pkg::MAX_FRAME_CHARS) begin
         bad_r <= 1'b1; // see RL1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Staging: data sits here until the whole query has checked out
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_r <= 9'h000;
         for (int i = 0; i < mvc_pkg::NUM_WORDS; i++) begin
            stage_r[i] <= mvc_pkg::WORD_RST;
         end
      end else if (is_colon) begin
         mask_r <= 9'h000;
      end else if (byte_v && in_data && dk[0] && widx < mvc_pkg::NUM_WORDS_16) begin
         stage_r[widx[3:0]] <= {dhi_r, rx_byte};
         mask_r[widx[3:0]] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame acceptance
   assign addr_match = addr_r == 8'({4'h0, axis_num} + mvc_pkg::ADDR_AXIS_OFFSET)
                       || addr_r == mvc_pkg::ADDR_BROADCAST; // see RL2

   always_comb begin
      vals_ok = 1'b1;
      if ((mask_r[mvc_pkg::W_POS_HI] || mask_r[mvc_pkg::W_POS_LO])
          && ($signed({nv[mvc_pkg::W_POS_HI], nv[mvc_pkg::W_POS_LO]})
              < $signed(mvc_pkg::POS_MIN)
              || $signed({nv[mvc_pkg::W_POS_HI], nv[mvc_pkg::W_POS_LO]})
              > $signed(mvc_pkg::POS_MAX))) begin
         vals_ok = 1'b0; // see RL5 see RL6
      end
      if ((mask_r[mvc_pkg::W_BAND_HI] || mask_r[mvc_pkg::W_BAND_LO])
          && ({nv[mvc_pkg::W_BAND_HI], nv[mvc_pkg::W_BAND_LO]} < mvc_pkg::VAL_MIN
              || {nv[mvc_pkg::W_BAND_HI], nv[mvc_pkg::W_BAND_LO]} > mvc_pkg::VAL_MAX)) begin
         vals_ok = 1'b0; // see RL10
      end
      if ((mask_r[mvc_pkg::W_SPD_HI] || mask_r[mvc_pkg::W_SPD_LO])
          && ({nv[mvc_pkg::W_SPD_HI], nv[mvc_pkg::W_SPD_LO]} < mvc_pkg::VAL_MIN
              || {nv[mvc_pkg::W_SPD_HI], nv[mvc_pkg::W_SPD_LO]} > mvc_pkg::VAL_MAX)) begin
         vals_ok = 1'b0; // see RL13
      end
      if (mask_r[mvc_pkg::W_ACC] && (nv[mvc_pkg::W_ACC] < mvc_pkg::ACC_MIN
                                     || nv[mvc_pkg::W_ACC] > mvc_pkg::ACC_MAX)) begin
         vals_ok = 1'b0; // see RL16
      end
   end

   // Byte count must match twice the count and the actual data length
   assign frame_ok = !bad_r && lrc_r == 8'h00 // see RL24
                     && func_r == mvc_pkg::FUNC_WRITE_MULTI && addr_match
                     && cnt_r != 16'h0000 && cnt_r <= mvc_pkg::NUM_WORDS_16
                     && {8'h00, bc_r} == {cnt_r[14:0], 1'b0} // see RL3
                     && byte_idx_r == 8'(bc_r + mvc_pkg::TAIL_BYTES) // see RL1
                     && vals_ok;
   assign commit = frame_end && frame_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Live registers, all words of one query land in the same edge
   for (genvar g = 0; g < mvc_pkg::NUM_WORDS; g++) begin : g_word
      assign nv[g] = mask_r[g] ? stage_r[g] : word_r[g];
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            word_r[g] <= (g == mvc_pkg::W_FLAGS) ? mvc_pkg::FLAGS_RST : mvc_pkg::WORD_RST;
         end else if (commit && mask_r[g]) begin
            word_r[g] <= stage_r[g]; // see RL25
         end else if (g == mvc_pkg::W_FLAGS && move_done) begin
            word_r[g] <= mvc_pkg::FLAGS_RST; // see RL22
         end
      end
   end

   assign positioning_band = {word_r[mvc_pkg::W_BAND_HI], word_r[mvc_pkg::W_BAND_LO]};
   assign move_speed = {word_r[mvc_pkg::W_SPD_HI], word_r[mvc_pkg::W_SPD_LO]};
   assign move_acceleration = word_r[mvc_pkg::W_ACC];
   assign push_current_limit = word_r[mvc_pkg::W_CUR]; // see RL19 see RL21
   assign motion_control_flags = word_r[mvc_pkg::W_FLAGS];
   assign push_mode = word_r[mvc_pkg::W_FLAGS][mvc_pkg::FLAG_PUSH_BIT]; // see RL23

   ////////////////////////////////////////////////////////////////////////////
   // Start evaluation one edge after commit, on the fully updated registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         eval_r <= 1'b0;
         trig_r <= 1'b0;
      end else begin
         eval_r <= commit; // see RL25
         // Band or flag words alone never start (see RL11)
         trig_r <= commit && |(mask_r & mvc_pkg::START_MASK); // see RL9 see RL15
      end
   end

   assign tgt = {word_r[mvc_pkg::W_POS_HI], word_r[mvc_pkg::W_POS_LO]};

   always_comb begin
      tgt_clamped = tgt;
      if ($signed(tgt) > $signed(soft_limit_hi)) begin
         tgt_clamped = rotary_index ? soft_limit_hi // see RL8
                                    : 32'(soft_limit_hi - mvc_pkg::SOFT_MARGIN); // see RL7
      end else if ($signed(tgt) < $signed(soft_limit_lo)) begin
         tgt_clamped = rotary_index ? soft_limit_lo // see RL8
                                    : 32'(soft_limit_lo + mvc_pkg::SOFT_MARGIN); // see RL7
      end
   end

   // Speed, acceleration and current writes also reach a running move through
   // the same start pulse; the engine retargets rather than restarts.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         move_start_r <= 1'b0;
         spd_alarm_r <= 1'b0;
         acc_alarm_r <= 1'b0;
         cmd_target_r <= 32'h0000_0000;
      end else begin
         move_start_r <= 1'b0;
         spd_alarm_r <= 1'b0;
         acc_alarm_r <= 1'b0;
         if (eval_r && trig_r) begin
            spd_alarm_r <= move_speed > max_speed; // see RL14
            acc_alarm_r <= move_acceleration > max_accel; // see RL17
            if (move_speed <= max_speed && move_acceleration <= max_accel) begin
               move_start_r <= 1'b1; // see RL9 see RL15 see RL18 see RL20
               cmd_target_r <= tgt_clamped;
            end
         end
      end
   end

   assign move_start = move_start_r;
   assign speed_alarm = spd_alarm_r;
   assign accel_alarm = acc_alarm_r;
   assign target_position = cmd_target_r;

   ////////////////////////////////////////////////////////////////////////////
   // Position complete: band is the tolerance only outside push motion
   assign pos_diff = 32'(current_pos - cmd_target_r);
   assign pos_abs = pos_diff[31] ? 32'(32'h0000_0000 - pos_diff) : pos_diff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_pos_r <= 1'b0;
      end else begin
         in_pos_r <= !push_mode && pos_abs <= positioning_band; // see RL10
      end
   end

   assign in_position = in_pos_r;

   ////////////////////////////////////////////////////////////////////////////
   // Echo, suppressed for broadcast
   mvc_resp_tx u_tx (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .go(commit && addr_r != mvc_pkg::ADDR_BROADCAST), // see RL24 see RL4
      .addr(addr_r),
      .func(func_r),
      .start_addr(sa_r),
      .reg_count(cnt_r),
      .busy(),
      .tx_char(tx_char),
      .tx_valid(tx_valid),
      .tx_ready(tx_ready)
   );

endmodule // mvc_move_cmd

// ### hw/mvc_pkg.sv
// Constants and types shared by the numeric move command write block.
// Assumes one 100 MHz clock and a character stream already framed by a UART.
package mvc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Frame characters and codes
   localparam logic [7:0] CH_COLON = 8'h3A;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] ADDR_BROADCAST = 8'h00;
   localparam logic [7:0] ADDR_AXIS_OFFSET = 8'h01;
   localparam logic [8:0] MAX_FRAME_CHARS = 9'h100;
   localparam logic [4:0] RESP_CHARS = 5'h11;
   localparam logic [7:0] HDR_BYTES = 8'h07;
   localparam logic [7:0] TAIL_BYTES = 8'h08;

   ////////////////////////////////////////////////////////////////////////////
   // Register window, word indices from the base address
   localparam logic [15:0] REG_BASE = 16'h9900;
   localparam int NUM_WORDS = 9;
   localparam logic [15:0] NUM_WORDS_16 = 16'h0009;
   localparam int W_POS_HI = 0;
   localparam int W_POS_LO = 1;
   localparam int W_BAND_HI = 2;
   localparam int W_BAND_LO = 3;
   localparam int W_SPD_HI = 4;
   localparam int W_SPD_LO = 5;
   localparam int W_ACC = 6;
   localparam int W_CUR = 7;
   localparam int W_FLAGS = 8;
   localparam logic [8:0] START_MASK = 9'h0E2;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam int FLAG_PUSH_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Value limits, units of 0.01 mm, 0.01 mm/s and 0.01 G
   localparam logic [31:0] POS_MIN = 32'hFFF0_BDC1;
   localparam logic [31:0] POS_MAX = 32'h000F_423F;
   localparam logic [31:0] VAL_MIN = 32'h0000_0001;
   localparam logic [31:0] VAL_MAX = 32'h000F_423F;
   localparam logic [15:0] ACC_MIN = 16'h0001;
   localparam logic [15:0] ACC_MAX = 16'h012C;
   localparam logic [31:0] SOFT_MARGIN = 32'h0000_0014;

   typedef enum logic [1:0] {MVC_IDLE, MVC_BODY, MVC_TRAIL} mvc_state_e;

endpackage

// ### hw/mvc_hex_dec.sv
// ASCII hex character to nibble decoder.
// Assumes the character is stable for the cycle it is flagged valid.
module mvc_hex_dec (
   // Character in
   input wire logic [7:0] ch,
   // Nibble out
   output logic [3:0] nib,
   output logic is_hex
);

   always_comb begin
      nib = 4'h0;
      is_hex = 1'b1;
      if (ch >= 8'h30 && ch <= 8'h39) begin
         nib = 4'(ch - 8'h30);
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
         nib = 4'(ch - 8'h37);
      end else if (ch >= 8'h61 && ch <= 8'h66) begin
         // Lower case accepted too; masters differ here
         nib = 4'(ch - 8'h57);
      end else begin
         is_hex = 1'b0;
      end
   end

endmodule // mvc_hex_dec

// ### hw/mvc_resp_tx.sv
// Echo response sender: header, address, function, start, count, LRC, CR LF.
// Assumes the consumer takes a character on tx_valid and tx_ready high.
module mvc_resp_tx (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Request
   input wire logic go,
   input wire logic [7:0] addr,
   input wire logic [7:0] func,
   input wire logic [15:0] start_addr,
   input wire logic [15:0] reg_count,
   output logic busy,
   // Character out
   output logic [7:0] tx_char,
   output logic tx_valid,
   input wire logic tx_ready
);

   logic [55:0] shift_r;
   logic [4:0] idx_r;
   logic busy_r;
   logic [7:0] char_r;
   logic [7:0] lrc;
   logic [4:0] idx_nxt;

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   assign lrc = 8'(8'h00 - (addr + func + start_addr[15:8] + start_addr[7:0]
                            + reg_count[15:8] + reg_count[7:0]));
   assign idx_nxt = 5'(idx_r + 5'h01);
   assign busy = busy_r;
   assign tx_valid = busy_r;
   assign tx_char = char_r;

   ////////////////////////////////////////////////////////////////////////////
   // Seventeen characters, a fresh LRC over the echoed fields (see RL4)
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         idx_r <= 5'h00;
         char_r <= 8'h00;
         shift_r <= 56'h0;
      end else if (go && !busy_r) begin
         busy_r <= 1'b1;
         idx_r <= 5'h00;
         char_r <= mvc_pkg::CH_COLON;
         shift_r <= {addr, func, start_addr, reg_count, lrc};
      end else if (busy_r && tx_ready) begin
         idx_r <= idx_nxt;
         if (idx_nxt == mvc_pkg::RESP_CHARS) begin
            busy_r <= 1'b0;
         end else if (idx_nxt == 5'(mvc_pkg::RESP_CHARS - 5'h01)) begin
            char_r <= mvc_pkg::CH_LF;
         end else if (idx_nxt == 5'(mvc_pkg::RESP_CHARS - 5'h02)) begin
            char_r <= mvc_pkg::CH_CR;
         end else begin
            char_r <= hex_char(shift_r[55:52]);
            shift_r <= {shift_r[51:0], 4'h0};
         end
      end
   end

endmodule // mvc_resp_tx

// ### tb/mvc_move_cmd_sva.sv
// Checker for the move command write block, bound to its top ports.
// Assumes one clock domain and an active low asynchronous reset.
module mvc_move_cmd_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Response side
   input wire logic [7:0] tx_char,
   input wire logic tx_valid,
   input wire logic tx_ready,
   // Limits
   input wire logic [31:0] soft_limit_lo,
   input wire logic [31:0] soft_limit_hi,
   input wire logic [31:0] max_speed,
   input wire logic [15:0] max_accel,
   // Motion side
   input wire logic move_start,
   input wire logic [31:0] target_position,
   input wire logic [31:0] move_speed,
   input wire logic [15:0] move_acceleration,
   input wire logic speed_alarm,
   input wire logic accel_alarm
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic [4:0] n_tx_r;
   ////////////////////////////////////////////////////////////////////////////
   // Accepted response characters
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) n_tx_r <= 5'h00;
      else if (!tx_valid) n_tx_r <= 5'h00;
      else if (tx_ready) n_tx_r <= n_tx_r + 5'h01;
   end
   sequence resp_open;
      $rose(tx_valid) ##0 tx_char == mvc_pkg::CH_COLON;
   endsequence
   sequence lf_taken;
      tx_valid && tx_ready && tx_char == mvc_pkg::CH_LF;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   resp_header_a: assert property ($rose(tx_valid) |-> resp_open)
      else $error("response does not open with header");
   resp_end_a: assert property (lf_taken |=> !tx_valid)
      else $error("response runs on after trailer");
   resp_len_a: assert property ($fell(tx_valid) |-> n_tx_r == mvc_pkg::RESP_CHARS)
      else $error("response length wrong");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
      else $error("response character dropped");
   start_pulse_a: assert property (move_start |=> !move_start)
      else $error("move start longer than one cycle");
   alarm_no_start_a: assert property (speed_alarm || accel_alarm |-> !move_start)
      else $error("move started with alarm");
   speed_alarm_a: assert property (speed_alarm |-> move_speed > max_speed)
      else $error("speed alarm without cause");
   accel_alarm_a: assert property (accel_alarm |-> move_acceleration > max_accel)
      else $error("accel alarm without cause");
   start_legal_a: assert property (move_start |->
      move_speed <= max_speed && move_acceleration <= max_accel)
      else $error("move started over limit");
   target_limit_a: assert property (move_start |-> $signed(target_position) <=
      $signed(soft_limit_hi) && $signed(target_position) >= $signed(soft_limit_lo))
      else $error("target beyond soft limit");
endmodule // mvc_move_cmd_sva

bind mvc_move_cmd mvc_move_cmd_sva i_sva (.*);

// ### tb/mvc_master.sv
// Modbus ASCII master model: frames queries with LRC, collects responses.
// Assumes the slave takes one character per rx_valid pulse.
module mvc_master (
   // Clock
   input wire logic sys_clk,
   // Query characters
   output logic [7:0] rx_char,
   output logic rx_valid,
   // Response characters
   input wire logic [7:0] tx_char,
   input wire logic tx_valid,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [7:0] mvc_bq_t[$];
   logic [7:0] rsp[$];
   initial {rx_char, rx_valid, tx_ready} = 10'h000;
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   task automatic encode(input mvc_bq_t b, input bit bad, output mvc_bq_t c);
      logic [7:0] s;
      s = 8'h00;
      c = {mvc_pkg::CH_COLON};
      foreach (b[i]) begin
         s = s + b[i];
         c.push_back(hx(b[i][7:4]));
         c.push_back(hx(b[i][3:0]));
      end
      s = (8'h00 - s) ^ {7'h00, bad};
      c.push_back(hx(s[7:4]));
      c.push_back(hx(s[3:0]));
      c.push_back(mvc_pkg::CH_CR);
      c.push_back(mvc_pkg::CH_LF);
   endtask
   // Idle line shows the inverse of the last character
   task automatic send(input mvc_bq_t c);
      foreach (c[i]) begin
         @(posedge sys_clk);
         rx_char <= c[i];
         rx_valid <= 1'b1;
         @(posedge sys_clk);
         rx_valid <= 1'b0;
         rx_char <= ~c[i];
      end
   endtask
   always @(posedge sys_clk) begin
      if (tx_valid && tx_ready) rsp.push_back(tx_char);
      tx_ready <= ($urandom % 3) != 0;
   end
endmodule // mvc_master

// ### tb/mvc_move_cmd_tb.sv
// Self-checking bench for the numeric move command write block.
// Assumes the master model and checker are compiled first.
module mvc_move_cmd_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst_b = 0, rx_valid, tx_valid, tx_ready, rotary_index = 0;
   logic move_done = 0, move_start, push_mode, in_position, speed_alarm, accel_alarm;
   logic [7:0] rx_char, tx_char, a;
   logic [3:0] axis_num = 4'h3;
   logic [31:0] soft_limit_lo = 32'hFFE1_7B80, soft_limit_hi = 32'h001E_8480;
   logic [31:0] max_speed = 32'h0000_1000, current_pos = 32'h0000_0000;
   logic [15:0] max_accel = 16'h012C, move_acceleration, push_current_limit, motion_control_flags;
   logic [31:0] target_position, positioning_band, move_speed;
   int fails = 0, n_checks = 0, n_st, n_sa, n_aa, cyc = 0, v;
   mvc_move_cmd i_dut (.*);
   mvc_master i_master (.*);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (move_start === 1'b1) n_st++;
      if (speed_alarm === 1'b1) n_sa++;
      if (accel_alarm === 1'b1) n_aa++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cnt(input int s, input int sa, input int aa);
      chk("move_start", s, n_st);
      chk("speed_alarm", sa, n_sa);
      chk("accel_alarm", aa, n_aa);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // One query and its echo
   task automatic frame(input logic [7:0] ad, input logic [15:0] st,
         input logic [15:0] w[$], input bit bad, input bit rsp);
      logic [7:0] b[$];
      logic [7:0] c[$];
      int n;
      b = {ad, 8'h10, st[15:8], st[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size())};
      foreach (w[i]) b = {b, w[i][15:8], w[i][7:0]};
      n_st = 0;
      n_sa = 0;
      n_aa = 0;
      i_master.rsp.delete();
      i_master.encode(b, 1'(bad), c);
      i_master.send(c);
      n = 0;
      while (rsp && i_master.rsp.size() < 17 && n < 500) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (20) @(posedge sys_clk);
      i_master.encode(b[0:5], 1'b0, c);
      if (!rsp) c.delete();
      chk("resp_len", c.size(), i_master.rsp.size());
      foreach (c[i]) if (i < i_master.rsp.size()) chk("resp_char", c[i], i_master.rsp[i]);
   endtask
   initial begin
      void'($urandom(32'hd8bd_9047));
      current_pos <= $urandom;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      chk("band_rst", 32'h0000_0000, positioning_band);
      chk("flags_rst", 32'h0000_0000, motion_control_flags);
      a = {4'h0, axis_num} + 8'h01;
      frame(a, 16'h9900, '{16'h0000, 16'h1388}, 0, 1);
      cnt(1, 0, 0);
      chk("target", 32'h0000_1388, target_position);
      frame(a, 16'h9900, '{16'hFFF0, 16'hBDC1}, 0, 1);
      chk("target", 32'hFFF0_BDC1, target_position);
      soft_limit_lo <= 32'hFFFF_D8F0;
      soft_limit_hi <= 32'h0000_2710;
      for (int r = 0; r < 2; r++) begin
         rotary_index <= r[0];
         frame(a, 16'h9900, '{16'h0000, 16'h4E20}, 0, 1);
         chk("target", r ? 32'h0000_2710 : 32'h0000_26FC, target_position);
         frame(a, 16'h9900, '{16'hFFFF, 16'hB1E0}, 0, 1);
         chk("target", r ? 32'hFFFF_D8F0 : 32'hFFFF_D904, target_position);
      end
      soft_limit_lo <= 32'hFFE1_7B80;
      soft_limit_hi <= 32'h001E_8480;
      frame(a, 16'h9902, '{16'h0000, 16'h0064}, 0, 1);
      cnt(0, 0, 0);
      chk("band", 32'h0000_0064, positioning_band);
      frame(a, 16'h9904, '{16'h0000, 16'h2000}, 0, 1);
      cnt(0, 1, 0);
      frame(a, 16'h9904, '{16'h0000, 16'h0800}, 0, 1);
      cnt(1, 0, 0);
      frame(a, 16'h9906, '{16'h012C}, 0, 1);
      cnt(1, 0, 0);
      max_accel <= 16'h0064;
      frame(a, 16'h9906, '{16'h0065}, 0, 1);
      cnt(0, 0, 1);
      frame(a, 16'h9906, '{16'h012D}, 0, 0);
      chk("accel", 32'h0000_0065, move_acceleration);
      max_accel <= 16'h012C;
      v = 32'h33 + $urandom % 32'h80;
      frame(a, 16'h9907, '{v[15:0]}, 0, 1);
      cnt(1, 0, 0);
      chk("current", v, push_current_limit);
      frame(a, 16'h9900, '{16'h0000, 16'h0001}, 1, 0);
      cnt(0, 0, 0);
      frame(8'h00, 16'h9900, '{16'h0000, 16'h0007}, 0, 0);
      cnt(1, 0, 0);
      chk("target", 32'h0000_0007, target_position);
      frame(a, 16'h9900, '{16'h0000, 16'h0100, 16'h0000, 16'h0050, 16'h0000,
         16'h0800, 16'h0064, 16'h0040, 16'h0002}, 0, 1);
      cnt(1, 0, 0);
      chk("push_mode", 1, push_mode);
      @(posedge sys_clk) move_done <= 1'b1;
      current_pos <= 32'h0000_0130;
      @(posedge sys_clk) move_done <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("flags", 32'h0000_0000, motion_control_flags);
      chk("in_pos", 1, in_position);
      for (int k = 0; k < 4; k++) begin
         v = int'($urandom % 1999999) - 999999;
         current_pos <= $urandom;
         frame(a, 16'h9900, '{v[31:16], v[15:0]}, 0, 1);
         chk("target", v, target_position);
      end
      test_done();
   end
endmodule // mvc_move_cmd_tb
